// [design/dmr_map.svh]
// Purpose: offsets, field positions, reset values of the monitor result registers
// Assumes: 8-bit register port, byte addresses as printed
// Notes:   definitions only
`ifndef DMR_MAP_SVH
`define DMR_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DMR_OFS_DATA_CFG      8'h55
`define DMR_OFS_BAT_HIGH      8'h56
`define DMR_OFS_BAT_LOW       8'h57
`define DMR_OFS_BIAS_HIGH     8'h58
`define DMR_OFS_BIAS_LOW      8'h59
`define DMR_OFS_C1P_HIGH      8'h5A
`define DMR_OFS_C1P_LOW       8'h5B
`define DMR_OFS_C1N_HIGH      8'h5C
`define DMR_OFS_C1N_LOW       8'h5D

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define DMR_BIT_FREEZE        0
`define DMR_BIT_OVERRIDE      1
`define DMR_CFG_WMASK         8'h03
`define DMR_RST_DATA_CFG      8'h00
`define DMR_RST_RESULT        12'h000
`define DMR_TAG_BAT           4'h0
`define DMR_TAG_BIAS          4'h1
`define DMR_TAG_C1P           4'h2
`define DMR_TAG_C1N           4'h3
`define DMR_NUM_SRC           4

`endif

// [design/dmr_monitor_regs.sv]
// Purpose: register readout of diagnostic monitor results with freeze and override
// Assumes: results arrive as a 12-bit word with a source index and a valid pulse
// Notes:   registers reached by plain port, read data one cycle after read strobe
//
// How it works
// - freeze bit 0 keeps results updating; 1 stops updates for stable readback
// - override bit selects battery and temperature data override, resets to 0
// - byte register bits 7..0 show result's upper eight bits, reset zero
// - nibble register bits 7..4 show result's lower four bits, reset zero
// - nibble bits 3..0 read a fixed channel tag per source
// - channel 1 negative nibble register resets to 0x03
// - each source has a byte/nibble pair at consecutive addresses from 0x56
// - config bits 7..2 are reserved, read zero, writes ignored
`timescale 1ns/1ps
`include "dmr_map.svh"
module dmr_monitor_regs
   import dmr_pkg::*;
(
   input  wire logic        clk_in,          // 40 MHz register clock
   input  wire logic        resetn_in,       // sync reset, active low
   input  wire dmr_byte_t   reg_addr_in,     // register address
   input  wire dmr_byte_t   reg_wdata_in,    // register write data
   input  wire logic        reg_wr_in,       // write strobe
   input  wire logic        reg_rd_in,       // read strobe
   output dmr_byte_t        reg_rdata_out,   // read data, cycle after strobe
   input  wire logic        res_valid_in,    // new conversion result pulse
   input  wire logic [1:0]  res_src_in,      // source of the new result
   input  wire dmr_result_t res_data_in,     // 12-bit conversion result
   output logic             freeze_out,      // results are frozen
   output logic             override_out     // supply and temperature override enable
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic      freeze;
      logic      override_en;
      logic      rd_pend;
      logic      rd_is_cfg;
      logic      rd_is_res;
      logic      rd_is_low;
      logic [1:0] rd_src;
      dmr_byte_t rdata;
   } dmr_state_s;

   dmr_state_s st_q;
   dmr_state_s st_d;

   logic        dec_cfg;
   logic        dec_res;
   logic [1:0]  dec_src;
   logic        dec_low;
   dmr_result_t word;
   logic        store_wr;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic dmr_tag_t src_tag(input logic [1:0] s);
      case (s)
         2'b00:   src_tag = `DMR_TAG_BAT;
         2'b01:   src_tag = `DMR_TAG_BIAS;
         2'b10:   src_tag = `DMR_TAG_C1P;
         default: src_tag = `DMR_TAG_C1N;
      endcase
   endfunction : src_tag

   dmr_reg_decode u_decode (
      .addr_in    (reg_addr_in),
      .is_cfg_out (dec_cfg),
      .is_res_out (dec_res),
      .src_out    (dec_src),
      .is_low_out (dec_low)
   );

   // one word per source: the whole 12-bit result is written at once
   assign store_wr = res_valid_in && !st_q.freeze;

   dmr_result_store #(
      .NUM_SRC (`DMR_NUM_SRC)
   ) u_store (
      .clk_in      (clk_in),
      .resetn_in   (resetn_in),
      .wr_en_in    (store_wr),
      .wr_idx_in   (res_src_in),
      .wr_data_in  (res_data_in),
      .rd_idx_in   (dec_src),
      .rd_data_out (word)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_d         = st_q;
      st_d.rd_pend = reg_rd_in;
      if (reg_rd_in) begin
         st_d.rd_is_cfg = dec_cfg;
         st_d.rd_is_res = dec_res;
         st_d.rd_is_low = dec_low;
         st_d.rd_src    = dec_src;
      end
      if (reg_wr_in && dec_cfg) begin
         st_d.freeze      = reg_wdata_in[`DMR_BIT_FREEZE];
         st_d.override_en = reg_wdata_in[`DMR_BIT_OVERRIDE];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   always_comb begin
      reg_rdata_out = 8'h00;
      if (st_q.rd_pend) begin
         if (st_q.rd_is_cfg) begin
            reg_rdata_out = {6'h00, st_q.override_en, st_q.freeze};
         end else if (st_q.rd_is_res && st_q.rd_is_low) begin
            reg_rdata_out = {word[3:0], src_tag(st_q.rd_src)};
         end else if (st_q.rd_is_res) begin
            reg_rdata_out = word[11:4];
         end else begin
            reg_rdata_out = 8'h00;
         end
      end
   end

   assign freeze_out   = st_q.freeze;
   assign override_out = st_q.override_en;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   a_freeze_blocks_write: assert property (st_q.freeze |-> !store_wr)
      else $error("result stored while frozen");
   a_unfrozen_stores: assert property (res_valid_in && !st_q.freeze |-> store_wr)
      else $error("result dropped while not frozen");
   a_override_write: assert property (reg_wr_in && dec_cfg |=> override_out == $past(reg_wdata_in[1]))
      else $error("override bit not written");
   a_high_byte: assert property (reg_rd_in && dec_res && !dec_low |=> reg_rdata_out == word[11:4])
      else $error("byte register wrong");
   a_low_nibble: assert property (reg_rd_in && dec_res && dec_low |=> reg_rdata_out[7:4] == word[3:0])
      else $error("nibble register wrong");
   a_tag_value: assert property (reg_rd_in && dec_res && dec_low |=> reg_rdata_out[3:0] == {2'b00, $past(dec_src)})
      else $error("channel tag wrong");
   a_c1n_tag: assert property (reg_rd_in && reg_addr_in == `DMR_OFS_C1N_LOW |=> reg_rdata_out[3:0] == 4'h3)
      else $error("channel 1 negative tag wrong");
   a_cfg_reserved: assert property (reg_rd_in && dec_cfg |=> reg_rdata_out[7:2] == 6'h00)
      else $error("reserved config bits nonzero");
   a_pair_hold: assert property (st_q.freeze && !reg_wr_in ##1 st_q.freeze |-> $stable(u_store.st_q.mem))
      else $error("pair changed while frozen");
   a_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
      else $error("read data without strobe");

   c_frozen_read: cover property (st_q.freeze && reg_rd_in && dec_res);
   c_update: cover property (store_wr);
   c_cfg_write: cover property (reg_wr_in && dec_cfg && reg_wdata_in[0]);

endmodule : dmr_monitor_regs

// [design/dmr_pkg.sv]
// Purpose: types of the monitor result register block
// Assumes: dmr_map.svh for numeric constants
// Notes:   types only
package dmr_pkg;

   typedef logic [7:0]  dmr_byte_t;
   typedef logic [11:0] dmr_result_t;
   typedef logic [3:0]  dmr_tag_t;

   typedef enum logic [1:0] {
      DMR_SRC_BAT  = 2'b00,
      DMR_SRC_BIAS = 2'b01,
      DMR_SRC_C1P  = 2'b10,
      DMR_SRC_C1N  = 2'b11
   } dmr_src_e;

endpackage : dmr_pkg

// [design/dmr_reg_decode.sv]
// Purpose: address decode of the monitor result register window
// Assumes: addresses 0x55..0x5D are mapped, others read zero
// Notes:   purely combinational
`timescale 1ns/1ps
`include "dmr_map.svh"
module dmr_reg_decode
   import dmr_pkg::*;
(
   input  wire dmr_byte_t   addr_in,      // register address
   output logic             is_cfg_out,   // address is the data config register
   output logic             is_res_out,   // address is a result register
   output logic [1:0]       src_out,      // source index of result address
   output logic             is_low_out    // nibble half of a pair
);

   dmr_byte_t rel;

   always_comb begin
      rel        = addr_in - `DMR_OFS_BAT_HIGH;
      is_cfg_out = (addr_in == `DMR_OFS_DATA_CFG);
      is_res_out = (addr_in >= `DMR_OFS_BAT_HIGH) && (addr_in <= `DMR_OFS_C1N_LOW);
      src_out    = rel[2:1];
      is_low_out = rel[0];
   end

endmodule : dmr_reg_decode

// [design/dmr_result_store.sv]
// Purpose: small memory of frozen 12-bit results, one word per source
// Assumes: write and read in the clk_in domain
// Notes:   read data come from a register
`timescale 1ns/1ps
`include "dmr_map.svh"
module dmr_result_store
   import dmr_pkg::*;
#(
   parameter int NUM_SRC = `DMR_NUM_SRC
) (
   input  wire logic        clk_in,      // clock
   input  wire logic        resetn_in,   // sync reset, active low
   input  wire logic        wr_en_in,    // write one word
   input  wire logic [1:0]  wr_idx_in,   // word index to write
   input  wire dmr_result_t wr_data_in,  // word to write
   input  wire logic [1:0]  rd_idx_in,   // word index to read
   output dmr_result_t      rd_data_out  // registered read word
);

   typedef struct packed {
      dmr_result_t [NUM_SRC-1:0] mem;
      dmr_result_t               rd;
   } dmr_store_s;

   dmr_store_s st_q;
   dmr_store_s st_d;

   always_comb begin
      st_d = st_q;
      if (wr_en_in) begin
         st_d.mem[wr_idx_in] = wr_data_in;
      end
      st_d.rd = st_q.mem[rd_idx_in];
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rd_data_out = st_q.rd;

endmodule : dmr_result_store

// [dv/diag_monitor_result_regs_bench.sv]
// Purpose: self-checking bench of the monitor result register block
// Assumes: register port read data in the cycle after the read strobe
// Notes:   inputs driven by non-blocking assignment at the rising edge
`timescale 1ns/1ps
`include "dmr_map.svh"
module diag_monitor_result_regs_bench
   import dmr_pkg::*;
();
   logic        clk_in       = 1'b0;
   logic        resetn_in    = 1'b0;
   dmr_byte_t   reg_addr_in  = 8'h00;
   dmr_byte_t   reg_wdata_in = 8'h00;
   logic        reg_wr_in    = 1'b0;
   logic        reg_rd_in    = 1'b0;
   dmr_byte_t   reg_rdata_out;
   logic        res_valid_in = 1'b0;
   logic [1:0]  res_src_in   = 2'h0;
   dmr_result_t res_data_in  = 12'h000;
   logic        freeze_out;
   logic        override_out;
   int          err_count    = 0;
   int          total_checks = 0;
   int          cyc          = 0;
   dmr_tag_t    tags[4]  = '{`DMR_TAG_BAT, `DMR_TAG_BIAS, `DMR_TAG_C1P, `DMR_TAG_C1N};
   dmr_result_t res_a[4] = '{12'hABC, 12'h5E1, 12'h3F7, 12'h80D};
   dmr_result_t res_b[4] = '{12'h123, 12'hFED, 12'h0F0, 12'h96A};

   dmr_monitor_regs dut_u (
      .clk_in        (clk_in),
      .resetn_in     (resetn_in),
      .reg_addr_in   (reg_addr_in),
      .reg_wdata_in  (reg_wdata_in),
      .reg_wr_in     (reg_wr_in),
      .reg_rd_in     (reg_rd_in),
      .reg_rdata_out (reg_rdata_out),
      .res_valid_in  (res_valid_in),
      .res_src_in    (res_src_in),
      .res_data_in   (res_data_in),
      .freeze_out    (freeze_out),
      .override_out  (override_out)
   );

   always #12.5 clk_in = ~clk_in;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic rd_chk(input dmr_byte_t a, input dmr_byte_t exp, input string what);
      @(posedge clk_in);
      reg_rd_in   <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_in);
      reg_rd_in   <= 1'b0;
      #1;
      check(what, reg_rdata_out, exp);
   endtask : rd_chk

   task automatic wr(input dmr_byte_t a, input dmr_byte_t d);
      @(posedge clk_in);
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge clk_in);
      reg_wr_in    <= 1'b0;
   endtask : wr

   // back-to-back result pulses, one per source
   task automatic push_all(input dmr_result_t v[4]);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in);
         res_valid_in <= 1'b1;
         res_src_in   <= 2'(i);
         res_data_in  <= v[i];
      end
      @(posedge clk_in);
      res_valid_in <= 1'b0;
   endtask : push_all

   task automatic chk_pairs(input dmr_result_t v[4]);
      dmr_byte_t a;
      for (int i = 0; i < 4; i++) begin
         a = `DMR_OFS_BAT_HIGH + 8'(2 * i);
         rd_chk(a, v[i][11:4], "result high");
         rd_chk(a + 8'h01, {v[i][3:0], tags[i]}, "result low");
      end
   endtask : chk_pairs

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   // ----------------------------------------
   // timeout
   // ----------------------------------------
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         end_of_test();
      end
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      dmr_byte_t exp;
      dmr_byte_t v;
      repeat (12) @(posedge clk_in);
      resetn_in <= 1'b1;
      // reset values, unmapped neighbours read zero
      check("freeze after reset", {7'h00, freeze_out}, 8'h00);
      check("override after reset", {7'h00, override_out}, 8'h00);
      for (int a = 8'h54; a <= 8'h5E; a++) begin
         exp = 8'h00;
         if (a >= 8'h56 && a <= 8'h5D && a[0]) begin
            exp = {4'h0, tags[(a - 8'h56) >> 1]};
         end
         rd_chk(8'(a), exp, "reset value");
      end
      $display("test reset values done");
      // results land in their pairs while not frozen
      push_all(res_a);
      chk_pairs(res_a);
      wr(`DMR_OFS_BAT_HIGH, 8'hFF);
      wr(`DMR_OFS_C1N_LOW, 8'hFF);
      chk_pairs(res_a);
      $display("test result pairs done");
      // config bits, reserved bits only ever written as zero and read back as zero
      for (int i = 0; i < 4; i++) begin
         v = 8'(i);
         wr(`DMR_OFS_DATA_CFG, v & `DMR_CFG_WMASK);
         #1;
         check("freeze bit", {7'h00, freeze_out}, {7'h00, v[0]});
         check("override bit", {7'h00, override_out}, {7'h00, v[1]});
         rd_chk(`DMR_OFS_DATA_CFG, v, "config readback");
      end
      $display("test config done");
      // frozen: new results dropped, both halves stay
      wr(`DMR_OFS_DATA_CFG, 8'h01);
      push_all(res_b);
      chk_pairs(res_a);
      wr(`DMR_OFS_DATA_CFG, 8'h00);
      chk_pairs(res_a);
      push_all(res_b);
      chk_pairs(res_b);
      $display("test freeze done");
      // reset in mid-run clears config and the channel 1 negative result pair
      wr(`DMR_OFS_DATA_CFG, 8'h03);
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      #1;
      check("freeze after rerun reset", {7'h00, freeze_out}, 8'h00);
      check("override after rerun reset", {7'h00, override_out}, 8'h00);
      rd_chk(`DMR_OFS_C1N_HIGH, 8'h00, "rerun reset high");
      rd_chk(`DMR_OFS_C1N_LOW, 8'h03, "rerun reset low");
      $display("test mid-run reset done");
      end_of_test();
   end
endmodule : diag_monitor_result_regs_bench
